// ===== hw/pll_rst_ctrl_pkg.sv
package pll_rst_ctrl_pkg;

  // Register byte offsets within the 1 KB region
  localparam logic [9:0] OFF_PERIPHERAL_IDENT    = 10'h0_00;
  localparam logic [9:0] OFF_RESET_CAUSE_STATUS  = 10'h0_E4;
  localparam logic [9:0] OFF_PLL_CONTROL         = 10'h1_00;
  localparam logic [9:0] OFF_LOOP_MULTIPLIER     = 10'h1_10;
  localparam logic [9:0] OFF_SYSCLK1_DIVIDER     = 10'h1_18;
  localparam logic [9:0] OFF_SYSCLK2_DIVIDER     = 10'h1_1C;
  localparam logic [9:0] OFF_SYSCLK3_DIVIDER     = 10'h1_20;
  localparam logic [9:0] OFF_POST_DIVIDER_CTRL   = 10'h1_28;
  localparam logic [9:0] OFF_BYPASS_DIVIDER      = 10'h1_2C;
  localparam logic [9:0] OFF_CONTROLLER_COMMAND  = 10'h1_38;
  localparam logic [9:0] OFF_CONTROLLER_STATUS   = 10'h1_3C;
  localparam logic [9:0] OFF_CLOCK_ALIGN_CONTROL = 10'h1_40;
  localparam logic [9:0] OFF_RATIO_CHANGE_STATUS = 10'h1_44;
  localparam logic [9:0] OFF_CLOCK_ENABLE_CTRL   = 10'h1_48;
  localparam logic [9:0] OFF_CLOCK_STATUS        = 10'h1_4C;
  localparam logic [9:0] OFF_SYSCLK_STATUS       = 10'h1_50;
  localparam logic [9:0] OFF_SYSCLK5_DIVIDER     = 10'h1_64;

  // Identification field positions
  localparam int ID_KIND_LSB    = 16;
  localparam int ID_CATEGORY_LSB = 8;
  localparam int ID_VERSION_LSB = 0;

  // Reset-cause flag positions
  localparam int system_reset_flag_bit   = 3;
  localparam int max_reset_flag_bit      = 2;
  localparam int ext_warm_reset_flag_bit = 1;
  localparam int power_on_flag_bit       = 0;

  // Control register field positions
  localparam int CTL_REFERENCE_SELECT = 8;
  localparam int CTL_ONES_HI          = 7;
  localparam int CTL_ONES_LO          = 6;
  localparam int CTL_ENABLE_SRC_GATE  = 5;
  localparam int CTL_OUTPUT_DISABLE   = 4;
  localparam int CTL_RESET_N          = 3;
  localparam int CTL_POWER_DOWN       = 1;
  localparam int CTL_MODE_SELECT      = 0;

  // Control register values after a global reset
  localparam logic CTL_RST_REFERENCE_SELECT = 1'b0;
  localparam logic CTL_RST_ENABLE_SRC_GATE  = 1'b1;
  localparam logic CTL_RST_OUTPUT_DISABLE   = 1'b1;
  localparam logic CTL_RST_RESET_N          = 1'b0;
  localparam logic CTL_RST_POWER_DOWN       = 1'b1;
  localparam logic CTL_RST_MODE_SELECT      = 1'b0;

  // Multiplier and divider geometry
  localparam int MULT_W       = 5;
  localparam int RATIO_W      = 4;
  localparam logic [4:0] MULT_RST = 5'h0_0;
  localparam logic [3:0] RATIO_RST = 4'h0;
  localparam int DIV_EN_BIT   = 15;
  localparam int GO_BIT       = 0;

  // Cycles the go-busy flag stays high after a go trigger
  localparam logic [3:0] GO_ALIGN_CYCLES = 4'h8;

  // Reset-cause encoding, two-bit binary; the status register holds it one-hot
  typedef enum logic [1:0] {
    CAUSE_POWER_ON = 2'b00,
    CAUSE_EXT_WARM = 2'b01,
    CAUSE_MAX      = 2'b10,
    CAUSE_SYSTEM   = 2'b11
  } reset_cause_t;

endpackage

// ===== hw/pll_reset_controller_regs.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// - Two instances, 1 KB each; second lacks dividers 3,5
// - Read-only ident: kind, category, version bytes
// - Reset cause cleared, then one bit latched
// - Cause bits 3..0: system, max, warm, power-on
// - Bit 8 selects external square reference
// - Mode bit ignored while source gate set
// - Bit 4 drives PLL output disable
// - Bit 3 is active-low PLL reset
// - Bit 1 powers PLL down; reserved bits
// - Bit 0 selects PLL output or bypass
// - Reserved control bits 7-6 read one
// - Five-bit multiplier, factor is field plus one
// - Global reset leaves PLL powered down
// - Go starts transition; busy until aligned
// - Divider divides by ratio plus one
module pll_reset_controller_regs
  import pll_rst_ctrl_pkg::*;
#(
  parameter bit          FULL_FEATURED = 1'b1,  // Zero for the reduced second instance
  parameter logic [7:0]  KIND_CODE     = 8'h5A,  // Arbitrary value
  parameter logic [7:0]  CATEGORY_CODE = 8'h3C,  // Arbitrary value
  parameter logic [7:0]  VERSION_CODE  = 8'h07   // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  reset_cause_in,     // Highest-priority cause of this reset
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             reference_select,   // 1: external square reference
  output logic             pll_output_disable,
  output logic             pll_reset_n,
  output logic             pll_power_down,
  output logic             pll_mode_select,    // Effective: 1 routes PLL output
  output logic [4:0]       loop_multiplier,
  output logic [5:0]       mult_factor,         // Applied factor, field plus one
  output logic             go_busy_flag
);

  localparam int NDIV = 3;  // Dividers 1, 2 and 3

  // Whole module state in one record
  typedef struct packed {
    logic               cause_taken;           // Cause latched since reset
    logic [3:0]         cause;                 // One-hot reset cause
    logic               ref_sel;
    logic               src_gate;
    logic               out_dis;
    logic               rst_n;
    logic               pwr_dn;
    logic               mode;
    logic [4:0]         mult;
    logic [NDIV-1:0]    div_en;
    logic [NDIV*4-1:0]  div_ratio;
    logic               div5_en;
    logic [3:0]         div5_ratio;
    logic [3:0]         go_cnt;                // Alignment countdown
    logic [31:0]        rdata;
  } state_t;

  state_t st;
  state_t next_st;

  logic        wr_acc;   // Write access phase
  logic        rd_acc;   // Read access phase
  logic [31:0] rd_mux;   // Read value for the addressed word

  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;

  // Read decode; unmapped and absent registers read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == OFF_PERIPHERAL_IDENT) begin
      rd_mux = {8'h00, KIND_CODE, CATEGORY_CODE, VERSION_CODE};
    end else if (paddr == OFF_RESET_CAUSE_STATUS) begin
      rd_mux = {28'h000_0000, st.cause};
    end else if (paddr == OFF_PLL_CONTROL) begin
      rd_mux[CTL_REFERENCE_SELECT] = st.ref_sel;
      rd_mux[CTL_ONES_HI]          = 1'b1;
      rd_mux[CTL_ONES_LO]          = 1'b1;
      rd_mux[CTL_ENABLE_SRC_GATE]  = st.src_gate;
      rd_mux[CTL_OUTPUT_DISABLE]   = st.out_dis;
      rd_mux[CTL_RESET_N]          = st.rst_n;
      rd_mux[CTL_POWER_DOWN]       = st.pwr_dn;
      rd_mux[CTL_MODE_SELECT]      = st.mode;
    end else if (paddr == OFF_LOOP_MULTIPLIER) begin
      rd_mux = {27'h000_0000, st.mult};
    end else if (paddr == OFF_SYSCLK1_DIVIDER) begin
      rd_mux[DIV_EN_BIT] = st.div_en[0];
      rd_mux[3:0]        = st.div_ratio[3:0];
    end else if (paddr == OFF_SYSCLK2_DIVIDER) begin
      rd_mux[DIV_EN_BIT] = st.div_en[1];
      rd_mux[3:0]        = st.div_ratio[7:4];
    end else if (paddr == OFF_SYSCLK3_DIVIDER && FULL_FEATURED) begin
      rd_mux[DIV_EN_BIT] = st.div_en[2];
      rd_mux[3:0]        = st.div_ratio[11:8];
    end else if (paddr == OFF_SYSCLK5_DIVIDER && FULL_FEATURED) begin
      rd_mux[DIV_EN_BIT] = st.div5_en;
      rd_mux[3:0]        = st.div5_ratio;
    end else if (paddr == OFF_CONTROLLER_STATUS) begin
      rd_mux[GO_BIT] = (st.go_cnt != 4'h0);
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Next-state logic: cause capture, register writes, go countdown
  always_comb begin
    next_st = st;
    // Cause is caught once, on the first edge after release
    if (!st.cause_taken) begin
      next_st.cause_taken = 1'b1;
      next_st.cause       = 4'h0;
      next_st.cause[reset_cause_in] = 1'b1;
    end
    // Go alignment countdown
    if (st.go_cnt != 4'h0) begin
      next_st.go_cnt = st.go_cnt - 4'h1;
    end
    // Writes to read-only or reserved bits fall through unused
    if (wr_acc) begin
      if (paddr == OFF_PLL_CONTROL) begin
        next_st.ref_sel  = pwdata[CTL_REFERENCE_SELECT];
        next_st.src_gate = pwdata[CTL_ENABLE_SRC_GATE];
        next_st.out_dis  = pwdata[CTL_OUTPUT_DISABLE];
        next_st.rst_n    = pwdata[CTL_RESET_N];
        next_st.pwr_dn   = pwdata[CTL_POWER_DOWN];
        next_st.mode     = pwdata[CTL_MODE_SELECT];
      end else if (paddr == OFF_LOOP_MULTIPLIER) begin
        next_st.mult = pwdata[MULT_W-1:0];
      end else if (paddr == OFF_SYSCLK1_DIVIDER) begin
        next_st.div_en[0]      = pwdata[DIV_EN_BIT];
        next_st.div_ratio[3:0] = pwdata[RATIO_W-1:0];
      end else if (paddr == OFF_SYSCLK2_DIVIDER) begin
        next_st.div_en[1]      = pwdata[DIV_EN_BIT];
        next_st.div_ratio[7:4] = pwdata[RATIO_W-1:0];
      end else if (paddr == OFF_SYSCLK3_DIVIDER && FULL_FEATURED) begin
        next_st.div_en[2]       = pwdata[DIV_EN_BIT];
        next_st.div_ratio[11:8] = pwdata[RATIO_W-1:0];
      end else if (paddr == OFF_SYSCLK5_DIVIDER && FULL_FEATURED) begin
        next_st.div5_en    = pwdata[DIV_EN_BIT];
        next_st.div5_ratio = pwdata[RATIO_W-1:0];
      end else if (paddr == OFF_CONTROLLER_COMMAND) begin
        // A second go while busy restarts the alignment window
        if (pwdata[GO_BIT]) begin
          next_st.go_cnt = GO_ALIGN_CYCLES;
        end
      end
    end
    // Read data is captured in a flop so it holds steady after the access ends
    if (rd_acc) begin
      next_st.rdata = rd_mux;
    end
  end

  // State register; global reset puts the PLL in bypass, reset and power-down
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st             <= '0;
      st.ref_sel     <= CTL_RST_REFERENCE_SELECT;
      st.src_gate    <= CTL_RST_ENABLE_SRC_GATE;
      st.out_dis     <= CTL_RST_OUTPUT_DISABLE;
      st.rst_n       <= CTL_RST_RESET_N;
      st.pwr_dn      <= CTL_RST_POWER_DOWN;
      st.mode        <= CTL_RST_MODE_SELECT;
      st.mult        <= MULT_RST;
    end else begin
      st <= next_st;
    end
  end

  // Read data: taken straight from the decoder during the access cycle,
  // then held from the flop once the access ends
  assign prdata = rd_acc ? rd_mux : st.rdata;

  assign reference_select   = st.ref_sel;
  assign pll_output_disable = st.out_dis;
  assign pll_reset_n        = st.rst_n;
  assign pll_power_down     = st.pwr_dn;
  // Mode bit only steers the bypass mux once the source gate is clear
  assign pll_mode_select    = st.mode && !st.src_gate;
  assign loop_multiplier    = st.mult;
  assign mult_factor        = {1'b0, st.mult} + 6'h01;
  assign go_busy_flag       = (st.go_cnt != 4'h0);

endmodule

// ===== sim/pll_regs_properties.sv
`timescale 1ns/1ps
// Ties control pins and readback to the register writes that cause them
module pll_regs_checker
  import pll_rst_ctrl_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        reference_select,
  input wire logic        pll_output_disable,
  input wire logic        pll_reset_n,
  input wire logic        pll_power_down,
  input wire logic        pll_mode_select,
  input wire logic [4:0]  loop_multiplier,
  input wire logic [5:0]  mult_factor,
  input wire logic        go_busy_flag
);
  logic acc;  // Access phase of any transfer
  assign acc = psel & penable;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_refsel_wr: assert property (acc && pwrite && paddr == OFF_PLL_CONTROL |=>
    reference_select == $past(pwdata[8])) else $error("reference select wrong");
  // Gate bit must override the mode bit
  a_mode_gated: assert property (acc && pwrite && paddr == OFF_PLL_CONTROL |=>
    pll_mode_select == ($past(pwdata[0]) && !$past(pwdata[5]))) else $error("mode wrong");
  a_disable_wr: assert property (acc && pwrite && paddr == OFF_PLL_CONTROL |=>
    pll_output_disable == $past(pwdata[4])) else $error("disable wrong");
  a_reset_n_wr: assert property (acc && pwrite && paddr == OFF_PLL_CONTROL |=>
    pll_reset_n == $past(pwdata[3])) else $error("pll reset wrong");
  a_power_wr: assert property (acc && pwrite && paddr == OFF_PLL_CONTROL |=>
    pll_power_down == $past(pwdata[1])) else $error("power down wrong");
  a_ctl_reserved: assert property (acc && !pwrite && paddr == OFF_PLL_CONTROL |->
    prdata[31:9] == 0 && prdata[7:6] == 2'b11 && !prdata[2]) else $error("reserved wrong");
  a_mult_wr: assert property (acc && pwrite && paddr == OFF_LOOP_MULTIPLIER |=>
    loop_multiplier == $past(pwdata[4:0])) else $error("multiplier wrong");
  a_factor_sum: assert property (mult_factor == loop_multiplier + 6'h01)
    else $error("factor wrong");
  a_ident_top: assert property (acc && !pwrite && paddr == OFF_PERIPHERAL_IDENT |->
    prdata[31:24] == 8'h00) else $error("ident top byte wrong");
  a_go_busy: assert property (acc && pwrite && paddr == OFF_CONTROLLER_COMMAND && pwdata[0]
    |=> go_busy_flag [*8]) else $error("go busy short");
  a_zero_wait: assert property (acc |-> pready) else $error("pready low");
endmodule

bind pll_reset_controller_regs pll_regs_checker chk (.core_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .reference_select, .pll_output_disable,
  .pll_reset_n, .pll_power_down, .pll_mode_select, .loop_multiplier, .mult_factor,
  .go_busy_flag);

// ===== sim/pll_reset_controller_regs_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module pll_reset_controller_regs_bench;
  import pll_rst_ctrl_pkg::*;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        ref_sel, out_dis, prst_n, pwr_dn, mode_sel, go_busy;
  logic [1:0]  cause;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] prdata_lite, rd_lite;  // Reduced instance read path
  logic [4:0]  mult;
  logic [5:0]  factor;
  int          n_fail = 0;
  int          n_tests = 0;
  // Identity values are arbitrary
  pll_reset_controller_regs #(.KIND_CODE(8'hA5), .CATEGORY_CODE(8'h3C), .VERSION_CODE(8'h07))
    uut (.core_clk(core_clk), .rst(rst), .reset_cause_in(cause), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reference_select(ref_sel),
    .pll_output_disable(out_dis), .pll_reset_n(prst_n), .pll_power_down(pwr_dn),
    .pll_mode_select(mode_sel), .loop_multiplier(mult), .mult_factor(factor),
    .go_busy_flag(go_busy));
  // Reduced instance shares the bus; only its read data is watched
  pll_reset_controller_regs #(.FULL_FEATURED(1'b0))
    uut_lite (.core_clk(core_clk), .rst(rst), .reset_cause_in(cause), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_lite), .pready(), .pslverr(), .reference_select(),
    .pll_output_disable(), .pll_reset_n(), .pll_power_down(), .pll_mode_select(),
    .loop_multiplier(), .mult_factor(), .go_busy_flag());
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // One APB transfer; never assumes a wait count, read data lands in rd
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    rd_lite = prdata_lite;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  // Cause is held so the first edge after release latches it
  task automatic do_reset(input logic [1:0] c);
    @(posedge core_clk);
    rst <= 1'b1; cause <= c;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  task automatic t_ident();
    apb(1'b1, OFF_PERIPHERAL_IDENT, 32'hFFFF_FFFF);
    rdchk(OFF_PERIPHERAL_IDENT, 32'h00A5_3C07);
  endtask
  task automatic t_control();
    apb(1'b1, OFF_PLL_CONTROL, 32'hFFFF_FF1F);  // Reserved bits written against their value
    rdchk(OFF_PLL_CONTROL, 32'h0000_01DB);
    `CHK({ref_sel, out_dis, prst_n, pwr_dn, mode_sel}, 5'h1F)
    apb(1'b1, OFF_PLL_CONTROL, 32'h0000_0021);  // Gate set hides the mode bit
    rdchk(OFF_PLL_CONTROL, 32'h0000_00E1);
    `CHK({ref_sel, out_dis, prst_n, pwr_dn, mode_sel}, 5'h00)
    // Bypass switch needs four reference cycles before more changes
    repeat (4) @(posedge core_clk);
  endtask
  task automatic t_mult_div();
    logic [9:0] offs[4];
    offs = '{OFF_SYSCLK1_DIVIDER, OFF_SYSCLK2_DIVIDER, OFF_SYSCLK3_DIVIDER, OFF_SYSCLK5_DIVIDER};
    apb(1'b1, OFF_LOOP_MULTIPLIER, 32'hFFFF_FFFF);  // No PLL runs here, any value is legal
    rdchk(OFF_LOOP_MULTIPLIER, 32'h0000_001F);
    `CHK(factor, 6'h20)
    foreach (offs[i]) begin
      apb(1'b1, offs[i], 32'hFFFF_FFFF);
      rdchk(offs[i], 32'h0000_800F);
      `CHK(rd_lite, (i >= 2) ? 32'h0000_0000 : 32'h0000_800F)
    end
    apb(1'b1, 10'h3FC, 32'hFFFF_FFFF);
    rdchk(10'h3FC, 32'h0000_0000);
  endtask
  // Busy must rise with the trigger and fall within a bounded wait
  task automatic t_go();
    int k;
    apb(1'b1, OFF_CONTROLLER_COMMAND, 32'h0000_0001);
    #1;
    `CHK(go_busy, 1'b1)
    rdchk(OFF_CONTROLLER_STATUS, 32'h0000_0001);
    // Look just after each edge so the count never races the design
    for (k = 0; k < 20 && go_busy === 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(go_busy, 1'b0)
    `CHK(k, 32'(GO_ALIGN_CYCLES) - 3)
    rdchk(OFF_CONTROLLER_STATUS, 32'h0000_0000);
  endtask
  // Every cause in turn; each reset also undoes the earlier setup
  task automatic t_causes();
    for (int c = 0; c < 4; c++) begin
      do_reset(2'(c));
      rdchk(OFF_RESET_CAUSE_STATUS, 32'h0000_0001 << c);
      rdchk(OFF_PLL_CONTROL, 32'h0000_00F2);
      rdchk(OFF_LOOP_MULTIPLIER, 32'h0000_0000);
      `CHK({pwr_dn, prst_n, mode_sel}, 3'b100)
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_fail++;
    print_verdict();
  end
  initial begin
    rst = 1'b1; cause = 2'b00; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 10'h000; pwdata = 32'h0000_0000;
    do_reset(2'b00);
    t_ident();
    t_control();
    t_mult_div();
    t_go();
    t_causes();
    print_verdict();
  end
endmodule
